//--- common/jit_cfg.svh
// constants of the in-frame response transmit control block
// assumes a byte-addressed axi4-lite bus with 8 address bits
`ifndef JIT_CFG_SVH
`define JIT_CFG_SVH
// register indices; byte address is four times the index
`define JIT_IDX_CTRL 8'h3d
`define JIT_IDX_SV 8'h3e
`define JIT_IDX_DATA 8'h3f
// transmit_control bit positions
`define JIT_B_FAST 6
`define JIT_B_NORM_BIT_FORMAT_SELECT 5
`define JIT_B_TRANSMIT_END_OF_DATA 4
`define JIT_B_SINGLE 3
`define JIT_B_MCRC 2
`define JIT_B_MNOCRC 1
`define JIT_CTRL_RST 8'h00
`define JIT_CTRL_WMASK 8'h7e
// state vector codes
`define JIT_SV_NONE 8'h00
`define JIT_SV_TRANSMIT_EMPTY_FLAG 8'h10
`define JIT_SV_ARB 8'h14
// crc and axi answers
`define JIT_CRC_INIT 8'hff
`define JIT_CRC_POLY 8'h1d
`define JIT_RESP_OK 2'h0
`define JIT_RESP_ERR 2'h2
`define JIT_LAST_BIT 3'h7
`endif

//--- common/jit_pkg.sv
// types of the in-frame response transmit control block
// assumes jit_cfg.svh for all numeric constants
package jit_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_NB, ST_DATA, ST_CRC, ST_EOD, ST_ONES, ST_WAITEOD, ST_RETRY
  } jit_state_t;
  typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_EOD, SYM_NONE} jit_sym_t;
  // symbol request toward the bit engine
  typedef struct packed {
    logic valid;
    jit_sym_t sym;
  } jit_txreq_t;
  // events reported by the symbol engine, same clock
  typedef struct packed {
    logic sym_done;
    logic eod_rx;
    logic sof_rx;
    logic err;
    logic arb_lost;
    logic arb_last2;
    logic byte_seen;
  } jit_link_ev_t;
  typedef struct packed {
    jit_state_t state;
    logic [7:0] ctl;
    logic [7:0] shadow;
    logic sh_full;
    logic [7:0] shift;
    logic [7:0] hold;
    logic [2:0] bitcnt;
    logic [7:0] crc;
    logic is_ifr;
    logic transmit_empty_flag;
    logic arb_flag;
    logic sv_read;
    logic eod_seen;
    logic ones_cnt;
    jit_txreq_t tx;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } jit_st_t;
endpackage

//--- rtl/jit_ctrl.sv
// transmit control of a vpw single-wire link: main message end, crc and responses
// assumes a symbol engine on SYS_CLK that sends requested symbols and reports events
//
// Operation
// - fast receive set: receive only at 41.6 kbps, else 10.4 kbps both ways
// - format bit picks normalization value: set gives 0 with crc, 1 without
// - end-of-data appends 8-bit crc after current byte and any shadow byte
// - setting end-of-data clears transmit empty condition
// - main message: end-of-data clears at first crc bit or on error
// - response: end-of-data clears on end-of-data received back or error
// - several response bits: single over multi-crc over multi-nocrc, readback raw
// - single response: after end-of-data send normalization bit then data byte
// - single bit clears on success, end-of-data set, or bus error
// - response bit written just after end-of-data stays clear, nothing sent
// - single mode arbitration loss: retry byte without normalization bit
// - single mode loss in last two bits: no extra ones
// - multi-crc: nb, bytes with transmit empty, then crc and end-of-data
// - multi-crc bit clears after crc and end-of-data, error or underrun
// - byte plus crc: end-of-data at empty gives byte, crc, no more empty
// - multi-crc arbitration loss: flag, stop, clear bit, no retry
// - multi modes loss in last two bits: send two extra logic ones
// - multi-nocrc: nb, bytes, end-of-data symbol after last byte, no crc
// - multi-nocrc bit clears after end-of-data sent, error or underrun
// - multi-nocrc arbitration loss: clear bit, no retry
// - responder sends an active normalization bit before its first byte
// - transmit empty clears on vector read then data write, or end-of-data
`timescale 1ns/1ns
`include "jit_cfg.svh"
module jit_ctrl (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // axi4-lite write
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // symbol engine
  input wire jit_pkg::jit_link_ev_t LINK_EV,
  output jit_pkg::jit_txreq_t TX_REQ,
  output logic FAST_RX
);
  import jit_pkg::*;

  jit_st_t r;
  jit_st_t n;

  // one crc step per sent bit, msb first
  function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc_bit = {c[6:0], 1'b0} ^ (fb ? `JIT_CRC_POLY : 8'h00);
  endfunction

  // priority encode of the three response bits
  function automatic logic [2:0] resp_eff(input logic [7:0] c);
    resp_eff = c[`JIT_B_SINGLE] ? 3'h4 : c[`JIT_B_MCRC] ? 3'h2 : c[`JIT_B_MNOCRC] ? 3'h1 : 3'h0;
  endfunction

  logic [2:0] mode;
  logic aw_fire;
  logic ar_fire;
  logic [7:0] waddr_idx;
  logic [7:0] raddr_idx;
  logic nb_val;
  logic [7:0] ctl_w;

  assign mode = resp_eff(r.ctl);
  // with crc: nb is the inverse of the format bit
  assign nb_val = mode[1] ? ~r.ctl[`JIT_B_NORM_BIT_FORMAT_SELECT] : r.ctl[`JIT_B_NORM_BIT_FORMAT_SELECT];
  assign aw_fire = r.awready & r.wready;
  assign ar_fire = r.arready;
  assign waddr_idx = {2'h0, S_AXI_AWADDR[7:2]};
  assign raddr_idx = {2'h0, S_AXI_ARADDR[7:2]};
  // response bits cannot be armed once the end-of-data is in; bits already
  // armed survive, so software may set end-of-data with a read-modify-write
  assign ctl_w = r.eod_seen ? (S_AXI_WDATA[7:0] & `JIT_CTRL_WMASK & (8'hf1 | r.ctl))
                            : (S_AXI_WDATA[7:0] & `JIT_CTRL_WMASK);

  always_comb
  begin
    n = r;
    n.arready = 1'b0;
    n.awready = 1'b0;
    n.wready = 1'b0;
    // ---- bus slave: write takes address and data together, answers next edge
    if (aw_fire)
    begin
      n.bvalid = 1'b1;
      n.bresp = `JIT_RESP_OK;
      if (waddr_idx == `JIT_IDX_CTRL)
      begin
        if (S_AXI_WSTRB[0])
        begin
          n.ctl = ctl_w;
          if (ctl_w[`JIT_B_TRANSMIT_END_OF_DATA])
          begin
            n.transmit_empty_flag = 1'b0;
            if (r.state == ST_RETRY || (r.is_ifr && mode[2]))
              n.ctl[`JIT_B_SINGLE] = 1'b0;
          end
        end
      end
      else if (waddr_idx == `JIT_IDX_DATA)
      begin
        if (S_AXI_WSTRB[0])
        begin
          n.shadow = S_AXI_WDATA[7:0];
          n.sh_full = 1'b1;
          if (r.sv_read)
            n.transmit_empty_flag = 1'b0;
          n.sv_read = 1'b0;
        end
      end
      else if (waddr_idx != `JIT_IDX_SV)
        n.bresp = `JIT_RESP_ERR;
    end
    else if (S_AXI_AWVALID && S_AXI_WVALID && !r.bvalid && !r.awready)
    begin
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (r.bvalid && S_AXI_BREADY)
      n.bvalid = 1'b0;
    // ---- bus slave: read
    // a vector read clears the loss flag; a loss in the same cycle still wins
    if (ar_fire)
    begin
      n.rvalid = 1'b1;
      n.rresp = `JIT_RESP_OK;
      n.rdata = 32'h0;
      if (raddr_idx == `JIT_IDX_CTRL)
        n.rdata[7:0] = r.ctl; // raw value read back
      else if (raddr_idx == `JIT_IDX_SV)
      begin
        n.rdata[7:0] = r.arb_flag ? `JIT_SV_ARB : r.transmit_empty_flag ? `JIT_SV_TRANSMIT_EMPTY_FLAG : `JIT_SV_NONE;
        n.arb_flag = 1'b0;
        n.sv_read = 1'b1;
      end
      else if (raddr_idx == `JIT_IDX_DATA)
        n.rdata[7:0] = r.shadow;
      else
        n.rresp = `JIT_RESP_ERR;
    end
    else if (S_AXI_ARVALID && !r.rvalid && !r.arready)
      n.arready = 1'b1;
    if (r.rvalid && S_AXI_RREADY)
      n.rvalid = 1'b0;
    // ---- frame tracking for the late-arming guard
    if (LINK_EV.sof_rx)
      n.eod_seen = 1'b0;
    if (LINK_EV.eod_rx)
      n.eod_seen = 1'b1;
    // ---- transmit sequencer
    case (r.state)
      ST_IDLE:
      begin
        if (LINK_EV.eod_rx && mode != 3'h0 && !r.ctl[`JIT_B_FAST] && !r.eod_seen)
        begin
          // response starts with the active normalization bit
          n.state = ST_NB;
          n.is_ifr = 1'b1;
          n.crc = `JIT_CRC_INIT;
          n.shift = r.shadow;
          n.hold = r.shadow;
          n.sh_full = 1'b0;
          n.bitcnt = 3'h0;
        end
        else if (r.sh_full && mode == 3'h0 && !r.ctl[`JIT_B_FAST])
        begin
          // main message byte; start of frame is the engine's job
          n.state = ST_DATA;
          n.is_ifr = 1'b0;
          n.crc = `JIT_CRC_INIT;
          n.shift = r.shadow;
          n.sh_full = 1'b0;
          n.bitcnt = 3'h0;
          if (!r.ctl[`JIT_B_TRANSMIT_END_OF_DATA])
            n.transmit_empty_flag = 1'b1;
        end
      end
      ST_NB:
      begin
        if (LINK_EV.sym_done)
        begin
          n.state = ST_DATA;
          if (!mode[2] && !r.ctl[`JIT_B_TRANSMIT_END_OF_DATA])
            n.transmit_empty_flag = 1'b1; // first byte now in the shift register
        end
      end
      ST_DATA:
      begin
        if (LINK_EV.arb_lost)
        begin
          if (r.is_ifr && mode[2])
            n.state = ST_RETRY; // no extra ones on retry
          else
          begin
            n.arb_flag = 1'b1;
            n.ctl[`JIT_B_MCRC] = 1'b0;
            n.ctl[`JIT_B_MNOCRC] = 1'b0;
            n.ones_cnt = 1'b0;
            n.state = LINK_EV.arb_last2 ? ST_ONES : ST_IDLE;
          end
        end
        else if (LINK_EV.sym_done)
        begin
          n.crc = crc_bit(r.crc, r.shift[7]);
          n.shift = {r.shift[6:0], 1'b0};
          n.bitcnt = r.bitcnt + 3'h1;
          if (r.bitcnt == `JIT_LAST_BIT)
          begin
            n.bitcnt = 3'h0;
            if (r.is_ifr && mode[2])
            begin
              n.ctl[`JIT_B_SINGLE] = 1'b0;
              n.state = ST_IDLE;
            end
            else if (r.sh_full)
            begin
              // shadow byte goes out before any crc
              n.shift = r.shadow;
              n.sh_full = 1'b0;
              if (!r.ctl[`JIT_B_TRANSMIT_END_OF_DATA])
                n.transmit_empty_flag = 1'b1;
            end
            else if (r.ctl[`JIT_B_TRANSMIT_END_OF_DATA] && r.is_ifr && mode[0])
              n.state = ST_EOD; // no crc in this mode
            else if (r.ctl[`JIT_B_TRANSMIT_END_OF_DATA])
            begin
              // byte then crc, no further empty report
              n.state = ST_CRC;
              n.shift = ~crc_bit(r.crc, r.shift[7]);
              if (!r.is_ifr)
                n.ctl[`JIT_B_TRANSMIT_END_OF_DATA] = 1'b0;
            end
            else
            begin
              // underrun: close with two ones, then drop the response
              n.state = ST_ONES;
              n.ones_cnt = 1'b0;
            end
          end
        end
      end
      ST_CRC:
      begin
        if (LINK_EV.sym_done)
        begin
          n.shift = {r.shift[6:0], 1'b0};
          n.bitcnt = r.bitcnt + 3'h1;
          if (r.bitcnt == `JIT_LAST_BIT)
          begin
            n.bitcnt = 3'h0;
            n.state = ST_EOD;
          end
        end
      end
      ST_EOD:
      begin
        if (LINK_EV.sym_done)
          n.state = r.is_ifr ? ST_WAITEOD : ST_IDLE;
      end
      ST_WAITEOD:
      begin
        // response is done only when the end-of-data comes back
        if (LINK_EV.eod_rx)
        begin
          n.ctl[`JIT_B_TRANSMIT_END_OF_DATA] = 1'b0;
          n.ctl[`JIT_B_MCRC] = 1'b0;
          n.ctl[`JIT_B_MNOCRC] = 1'b0;
          n.state = ST_IDLE;
        end
      end
      ST_ONES:
      begin
        if (LINK_EV.sym_done)
        begin
          n.ones_cnt = 1'b1;
          if (r.ones_cnt)
          begin
            n.ctl[`JIT_B_MCRC] = 1'b0;
            n.ctl[`JIT_B_MNOCRC] = 1'b0;
            n.state = ST_IDLE;
          end
        end
      end
      ST_RETRY:
      begin
        // a retry raises no loss flag; the single response just waits its turn
        // wait for the winning byte, then resend without normalization bit
        if (!mode[2])
          n.state = ST_IDLE;
        else if (LINK_EV.byte_seen)
        begin
          n.shift = r.hold;
          n.bitcnt = 3'h0;
          n.state = ST_DATA;
        end
      end
      default:
        n.state = ST_IDLE;
    endcase
    // a bus error drops the transfer and clears end-of-data and the three response bits in any state but idle
    // placed last so it outranks every state change made above
    if (LINK_EV.err && r.state != ST_IDLE)
    begin
      n.ctl[`JIT_B_TRANSMIT_END_OF_DATA] = 1'b0;
      n.ctl[`JIT_B_SINGLE] = 1'b0;
      n.ctl[`JIT_B_MCRC] = 1'b0;
      n.ctl[`JIT_B_MNOCRC] = 1'b0;
      n.state = ST_IDLE;
    end
    // symbol request follows the next state so the port is a flop
    n.tx.valid = 1'b1;
    case (n.state)
      ST_NB: n.tx.sym = nb_val ? SYM_ONE : SYM_ZERO;
      ST_DATA: n.tx.sym = n.shift[7] ? SYM_ONE : SYM_ZERO;
      ST_CRC: n.tx.sym = n.shift[7] ? SYM_ONE : SYM_ZERO;
      ST_EOD: n.tx.sym = SYM_EOD;
      ST_ONES: n.tx.sym = SYM_ONE;
      default:
      begin
        n.tx.valid = 1'b0;
        n.tx.sym = SYM_NONE;
      end
    endcase
  end

  // single state register; everything resets to zero or idle, the symbol field to none
  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      r <= '0;
      r.state <= ST_IDLE;
      r.ctl <= `JIT_CTRL_RST;
      r.tx.sym <= SYM_NONE;
    end
    else
      r <= n;
  end

  // ports straight from the state register
  assign S_AXI_AWREADY = r.awready;
  assign S_AXI_WREADY = r.wready;
  assign S_AXI_BVALID = r.bvalid;
  assign S_AXI_BRESP = r.bresp;
  assign S_AXI_ARREADY = r.arready;
  assign S_AXI_RVALID = r.rvalid;
  assign S_AXI_RDATA = r.rdata;
  assign S_AXI_RRESP = r.rresp;
  assign TX_REQ = r.tx;
  assign FAST_RX = r.ctl[`JIT_B_FAST]; // engine runs 4x receive only
endmodule

//--- verif/jit_sym_model.sv
// far-side symbol engine model: finishes each requested symbol after dly+1 cycles
// assumes the block's clock; the bench injects every other link event
`timescale 1ns/1ns
module jit_sym_model
  import jit_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // request and stimulus
  input wire jit_pkg::jit_txreq_t tx_req,
  input wire logic [3:0] dly,
  input wire jit_pkg::jit_link_ev_t inj,
  // events toward the block
  output jit_pkg::jit_link_ev_t ev
);
  logic [3:0] cnt;
  logic done;
  // one pulse per symbol; a gap cycle after it so a held request is not counted twice
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt <= 4'h0;
      done <= 1'b0;
    end
    else
    begin
      done <= tx_req.valid && !done && cnt == dly;
      cnt <= (!tx_req.valid || done || cnt == dly) ? 4'h0 : cnt + 4'h1;
    end
  // merge bench events with the model's completion
  always_comb
  begin
    ev = inj;
    ev.sym_done = done;
  end
endmodule

//--- verif/jit_ctrl_props.sv
// port assertions of the transmit control block
// assumes one clock domain; bound into jit_ctrl at the foot
`timescale 1ns/1ns
`include "jit_cfg.svh"
module jit_ctrl_props
  import jit_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // register bus
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  // link side
  input wire jit_pkg::jit_link_ev_t LINK_EV,
  input wire jit_pkg::jit_txreq_t TX_REQ,
  input wire logic FAST_RX
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  wire ctrl_wr = S_AXI_AWREADY && S_AXI_WREADY && S_AXI_WSTRB[0]
    && {2'b00, S_AXI_AWADDR[7:2]} == `JIT_IDX_CTRL;
  sequence s_wr_seen;
    S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && !S_AXI_AWREADY;
  endsequence
  sequence s_wr_take;
    S_AXI_AWREADY && S_AXI_WREADY ##1 S_AXI_BVALID && !S_AXI_AWREADY;
  endsequence
  property p_wr_answer;
    s_wr_seen |=> s_wr_take;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer out of time");
  property p_unmapped;
    S_AXI_ARREADY && S_AXI_ARADDR[7:2] < 6'h3d |=> S_AXI_RVALID
      && S_AXI_RRESP == `JIT_RESP_ERR && S_AXI_RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_ctrl_bits;
    S_AXI_ARREADY && S_AXI_ARADDR[7:2] == 6'h3d |=> S_AXI_RDATA[31:7] == 25'h0 && !S_AXI_RDATA[0];
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("unused control bits read high");
  property p_fast_hold;
    !$stable(FAST_RX) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  a_fast_hold: assert property (p_fast_hold) else $error("fast receive moved alone");
  property p_fast_quiet;
    $rose(TX_REQ.valid) |-> !FAST_RX;
  endproperty
  a_fast_quiet: assert property (p_fast_quiet) else $error("sending in fast receive");
  property p_nb_first;
    LINK_EV.eod_rx && !TX_REQ.valid |=> !TX_REQ.valid || TX_REQ.sym inside {SYM_ZERO, SYM_ONE};
  endproperty
  a_nb_first: assert property (p_nb_first) else $error("response opens badly");
  property p_ones_after;
    LINK_EV.arb_lost && LINK_EV.arb_last2 && TX_REQ.valid |=>
      (!TX_REQ.valid || TX_REQ.sym == SYM_ONE) [*2];
  endproperty
  a_ones_after: assert property (p_ones_after) else $error("late loss not ones");
  property p_stop_after;
    LINK_EV.arb_lost && !LINK_EV.arb_last2 |=> !TX_REQ.valid [*3];
  endproperty
  a_stop_after: assert property (p_stop_after) else $error("sending after loss");
  property p_err_stop;
    LINK_EV.err && TX_REQ.valid |=> !TX_REQ.valid [*3];
  endproperty
  a_err_stop: assert property (p_err_stop) else $error("sending after error");
  property p_req_hold;
    TX_REQ.valid && !LINK_EV.sym_done && !LINK_EV.arb_lost && !LINK_EV.err |=> $stable(TX_REQ);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("symbol request changed early");
endmodule
bind jit_ctrl jit_ctrl_props i_props (.SYS_CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARADDR,
  .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .LINK_EV, .TX_REQ, .FAST_RX);

//--- verif/j1850_ifr_transmit_control_test.sv
// self-checking bench of the transmit control block with a far-side symbol model
// assumes jit_cfg.svh indices and a 20 MHz clock
`timescale 1ns/1ns
`include "jit_cfg.svh"
module j1850_ifr_transmit_control_test;
  import jit_pkg::*;
  localparam logic [6:0] ev_eod = 7'h20, ev_sof = 7'h10, ev_err = 7'h08, ev_arb = 7'h04;
  logic clk = 1'b0, rst_b = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic awready, wready, bvalid, arready, rvalid, fast;
  logic [1:0] bresp, rresp, rr, rb;
  jit_link_ev_t ev, inj = '0;
  jit_txreq_t req;
  logic [3:0] dly = 4'h0;
  jit_sym_t obs[$], exp_q[$];
  int bad_count = 0, total_checks = 0;
  always #25 clk = ~clk;
  jit_ctrl i_dut (.SYS_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LINK_EV(ev),
    .TX_REQ(req), .FAST_RX(fast));
  jit_sym_model i_far (.clk(clk), .rst_b(rst_b), .tx_req(req), .dly(dly), .inj(inj), .ev(ev));
  // log every finished symbol in order
  always @(posedge clk)
    if (rst_b && ev.sym_done && req.valid)
      obs.push_back(req.sym);
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    total_checks++;
    if (got !== want)
    begin
      bad_count++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  // bus cycles: payload held until its ready, answer taken at its valid
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {idx[5:0], 2'b00};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    @(posedge clk);
    while (!awready) @(posedge clk);
    awv <= 1'b0;
    wv <= 1'b0;
    while (!bvalid) @(posedge clk);
    rb = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge clk);
    araddr <= {idx[5:0], 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arv <= 1'b0;
    while (!rvalid) @(posedge clk);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] want);
    rd(idx);
    chk(rv, want, "register");
  endtask
  task automatic wait_sv(input logic [7:0] v);
    rd(`JIT_IDX_SV);
    while (rv[7:0] !== v) rd(`JIT_IDX_SV);
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    inj <= jit_link_ev_t'(e);
    @(posedge clk);
    inj <= '0;
  endtask
  task automatic exp_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      exp_q.push_back(b[i] ? SYM_ONE : SYM_ZERO);
  endtask
  // crc over two bytes, msb first, sent inverted
  function automatic logic [7:0] crc_of(input logic [15:0] v);
    logic [7:0] c = 8'hff;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h1d : 8'h00);
    return ~c;
  endfunction
  task automatic cmp_syms(input string what);
    chk(obs.size(), exp_q.size(), what);
    foreach (exp_q[i])
      if (i < obs.size())
        chk(obs[i], exp_q[i], what);
    obs = {};
    exp_q = {};
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, about twenty times the expected run
  initial
  begin
    #1000000;
    bad_count++;
    $display("FAIL %0t watchdog", $time);
    complete_run();
  end
  initial
  begin
    logic [7:0] d0, d1, cv;
    void'($urandom(29318));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rdc(`JIT_IDX_CTRL, 32'h0);
    rd(8'h10);
    chk(rr, `JIT_RESP_ERR, "unmapped");
    wr(8'h10, 8'h00);
    chk(rb, `JIT_RESP_ERR, "unmapped write");
    wr(`JIT_IDX_CTRL, 8'h40);
    chk(rb, `JIT_RESP_OK, "write answer");
    rdc(`JIT_IDX_CTRL, 32'h40);
    chk(fast, 1'b1, "fast");
    wr(`JIT_IDX_CTRL, 8'h00);
    rdc(`JIT_IDX_CTRL, 32'h0);
    chk(fast, 1'b0, "fast");
    $display("test registers done");
    // single byte response, both formats, prompt then slow far side
    for (int f = 0; f < 2; f++)
    begin
      dly <= f ? 4'h3 : 4'h0;
      d0 = 8'($urandom);
      pulse(ev_sof);
      wr(`JIT_IDX_CTRL, {2'b00, f[0], 5'h08});
      wr(`JIT_IDX_DATA, d0);
      pulse(ev_eod);
      exp_q.push_back(f ? SYM_ONE : SYM_ZERO);
      exp_byte(d0);
      rd(`JIT_IDX_CTRL);
      while (rv[3]) rd(`JIT_IDX_CTRL);
      cmp_syms("single");
      rdc(`JIT_IDX_CTRL, {26'h0, f[0], 5'h0});
    end
    $display("test single done");
    // two-byte responses, with crc (two bits written) and without
    for (int m = 0; m < 2; m++)
    begin
      cv = m ? 8'h22 : 8'h26;
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      pulse(ev_sof);
      wr(`JIT_IDX_CTRL, cv);
      rdc(`JIT_IDX_CTRL, cv);
      wr(`JIT_IDX_DATA, d0);
      pulse(ev_eod);
      wait_sv(`JIT_SV_TRANSMIT_EMPTY_FLAG);
      wr(`JIT_IDX_DATA, d1);
      wait_sv(`JIT_SV_TRANSMIT_EMPTY_FLAG);
      wr(`JIT_IDX_CTRL, cv | 8'h10);
      rdc(`JIT_IDX_SV, 32'h0);
      while (obs.size() == 0 || obs[$] !== SYM_EOD) @(posedge clk);
      pulse(ev_eod);
      rdc(`JIT_IDX_CTRL, cv & 8'h20);
      exp_q.push_back(m ? SYM_ONE : SYM_ZERO);
      exp_byte(d0);
      exp_byte(d1);
      if (!m)
        exp_byte(crc_of({d0, d1}));
      exp_q.push_back(SYM_EOD);
      cmp_syms("multi");
    end
    $display("test multi done");
    pulse(ev_sof);
    pulse(ev_eod);
    wr(`JIT_IDX_CTRL, 8'h08);
    rdc(`JIT_IDX_CTRL, 32'h0);
    repeat (20) @(posedge clk);
    cmp_syms("masked");
    $display("test late arm done");
    // loss early, loss in the last two bits, bus error
    for (int k = 0; k < 3; k++)
    begin
      pulse(ev_sof);
      wr(`JIT_IDX_CTRL, 8'h04);
      wr(`JIT_IDX_DATA, 8'h00);
      pulse(ev_eod);
      while (obs.size() < 7) @(posedge clk);
      pulse(k == 2 ? ev_err : (k ? ev_arb | 7'h02 : ev_arb));
      repeat (30) @(posedge clk);
      rdc(`JIT_IDX_CTRL, 32'h0);
      if (k < 2)
        rdc(`JIT_IDX_SV, `JIT_SV_ARB);
      exp_q.push_back(SYM_ONE);
      repeat (6) exp_q.push_back(SYM_ZERO);
      if (k == 1)
        repeat (2) exp_q.push_back(SYM_ONE);
      cmp_syms("loss");
    end
    $display("test loss done");
    // single response losing in the last two bits: resend whole byte, no ones
    d0 = 8'($urandom);
    pulse(ev_sof);
    wr(`JIT_IDX_CTRL, 8'h08);
    wr(`JIT_IDX_DATA, d0);
    pulse(ev_eod);
    while (obs.size() < 7) @(posedge clk);
    pulse(ev_arb | 7'h02);
    repeat (6) @(posedge clk);
    pulse(7'h01);
    rd(`JIT_IDX_CTRL);
    while (rv[3] !== 1'b0) rd(`JIT_IDX_CTRL);
    exp_q.push_back(SYM_ZERO);
    for (int i = 7; i > 1; i--)
      exp_q.push_back(d0[i] ? SYM_ONE : SYM_ZERO);
    exp_byte(d0);
    cmp_syms("retry");
    rdc(`JIT_IDX_CTRL, 32'h0);
    $display("test retry done");
    complete_run();
  end
endmodule
